// *** src/cop_pkg.sv ***
// Purpose: shared constants and types for the clock output and power interlock block
// Assumes: one system clock, control bits arrive as plain ports
// Notes: clock output select encodings, divider counts and the write gate fields live here
//
// Contract
// - direct select 1 and source 00b with main clock drives undivided main clock out.
// - direct select 0 and source 10b with main clock drives main clock divided by 8.
// - direct select 0 and source 11b with main clock drives main clock divided by 32.
// - sub clock selected, direct 0, source 01b drives the sub clock out.
// - main clock counts as selected only when sub and on-chip selects are both 0.
// - clock select and output settings take writes only while the unlock bit is 1.
// - data-flash reads get one wait when either wait-control bit is set.
// - a reset with the mode strap high blocks reads of internal program memory.
package cop_pkg;
	localparam logic [1:0] SRC_MAIN = 2'h0;
	localparam logic [1:0] SRC_SUB = 2'h1;
	localparam logic [1:0] SRC_DIV8 = 2'h2;
	localparam logic [1:0] SRC_DIV32 = 2'h3;
	localparam int DIV8_HALF = 4;
	localparam int DIV32_HALF = 16;
	localparam logic [3:0] DIV_CNT_RST = 4'h0;
	localparam logic [1:0] SRC_RST = 2'h0;
	localparam logic DIRECT_RST = 1'b0;
	localparam logic SUBSEL_RST = 1'b0;
	localparam logic OSCSEL_RST = 1'b0;

	// one software write of the protected clock settings
	typedef struct packed {
		logic wrEn;
		logic subSel;
		logic oscSel;
		logic directSel;
		logic [1:0] srcField;
	} cop_clkwr_t;

	// flash access request and its target memory
	typedef struct packed {
		logic req;
		logic isDataFlash;
		logic isProgRom;
	} cop_rdreq_t;
endpackage

// *** src/cop_div_cell.sv ***
`timescale 1ns/10ps
// Purpose: divide the main clock input level by a programmable half period
// Assumes: mainClkIn is a level sampled on clk_sys
// Notes: counts edges of the sampled main clock, so output toggles follow it
module cop_div_cell
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clkEn,
	// divider control
	input wire logic mainEdge,
	input wire logic [3:0] halfCount,
	// divided clock
	output logic divOut
);
	import cop_pkg::*;

	logic [3:0] cnt_q;

	// count main clock edges, toggle at each half period
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= DIV_CNT_RST;
			divOut <= 1'b0;
		end
		else if (clkEn && mainEdge)
		begin
			if (cnt_q == halfCount)
			begin
				cnt_q <= DIV_CNT_RST;
				divOut <= ~divOut;
			end
			else
				cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule

// *** src/cop_clock_ctl.sv ***
`timescale 1ns/10ps
// Purpose: clock output selection, write unlock gate, flash wait and strap read block
// Assumes: main and sub clocks arrive as levels sampled on clk_sys
// Notes: the output mux follows the latched settings; unsupported combinations drive low
module cop_clock_ctl
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clkEn,
	// oscillator levels
	input wire logic mainClkIn,
	input wire logic subClkIn,
	// protected clock settings
	input wire logic clockWriteUnlock,
	input wire cop_pkg::cop_clkwr_t clkWr,
	// flash access
	input wire logic waitInsertBit,
	input wire logic dataFlashWaitBit,
	input wire logic processorModeStrap,
	input wire cop_pkg::cop_rdreq_t rdReq,
	// status and outputs
	output logic clockOutputPin,
	output logic mainSelected,
	output logic readWait,
	output logic progRomBlock,
	output logic progRomGrant
);
	import cop_pkg::*;

	logic subSel_q;
	logic oscSel_q;
	logic directSel_q;
	logic [1:0] src_q;
	logic mainLvl_q;
	logic mainEdge;
	logic div8;
	logic div32;
	logic strapCaught_q;
	logic outNext;

	// main is selected only when both other selects are clear
	assign mainSelected = !subSel_q && !oscSel_q;

	// settings change only while unlocked; locked writes are dropped silently
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			subSel_q <= SUBSEL_RST;
			oscSel_q <= OSCSEL_RST;
			directSel_q <= DIRECT_RST;
			src_q <= SRC_RST;
		end
		else if (clkEn && clkWr.wrEn && clockWriteUnlock)
		begin
			subSel_q <= clkWr.subSel;
			oscSel_q <= clkWr.oscSel;
			directSel_q <= clkWr.directSel;
			src_q <= clkWr.srcField;
		end
	end

	// remember last main clock level to find its rising edge
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			mainLvl_q <= 1'b0;
		else if (clkEn)
			mainLvl_q <= mainClkIn;
	end

	assign mainEdge = mainClkIn && !mainLvl_q;

	// one divider cell per ratio keeps both phases free running
	cop_div_cell u_div8
	(
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clkEn(clkEn),
		.mainEdge(mainEdge),
		.halfCount(4'(DIV8_HALF - 1)),
		.divOut(div8)
	);

	cop_div_cell u_div32
	(
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clkEn(clkEn),
		.mainEdge(mainEdge),
		.halfCount(4'(DIV32_HALF - 1)),
		.divOut(div32)
	);

	// output mux; main clock is passed as sampled level, one cycle late
	always_comb
	begin
		outNext = 1'b0;
		if (mainSelected && directSel_q && src_q == SRC_MAIN)
			outNext = mainClkIn;
		else if (mainSelected && !directSel_q && src_q == SRC_DIV8)
			outNext = div8;
		else if (mainSelected && !directSel_q && src_q == SRC_DIV32)
			outNext = div32;
		else if (subSel_q && !directSel_q && src_q == SRC_SUB)
			outNext = subClkIn;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			clockOutputPin <= 1'b0;
		else if (clkEn)
			clockOutputPin <= outNext;
	end

	// data-flash read gets a wait when either wait bit is set
	assign readWait = rdReq.req && rdReq.isDataFlash && (waitInsertBit || dataFlashWaitBit);

	// strap is caught by a clocked process once reset has released
	logic armed_q;
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			armed_q <= 1'b0;
		else if (clkEn)
			armed_q <= 1'b1;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			strapCaught_q <= 1'b0;
		else if (clkEn && !armed_q)
			strapCaught_q <= processorModeStrap;
	end

	assign progRomBlock = strapCaught_q;
	assign progRomGrant = rdReq.req && rdReq.isProgRom && !strapCaught_q;

	// a settings write has two steps: the strobe edge, then the registers seen one edge later
	sequence s_open_write;
		clkEn && clkWr.wrEn && clockWriteUnlock;
	endsequence

	// a frozen enable refuses the strobe just as a locked gate does
	sequence s_shut_write;
		clkWr.wrEn && (!clockWriteUnlock || !clkEn);
	endsequence

	chk_locked_write_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_shut_write |=> $stable(src_q) && $stable(subSel_q) && $stable(oscSel_q) && $stable(directSel_q))
		else $error("locked write changed clock settings");

	chk_open_write_lands: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_open_write |=> src_q == $past(clkWr.srcField) && directSel_q == $past(clkWr.directSel))
		else $error("unlocked write did not land");

	chk_main_select_def: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_open_write ##0 (clkWr.subSel || clkWr.oscSel) |=> !mainSelected)
		else $error("main still selected after another source was chosen");

	chk_main_select_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_open_write ##0 (!clkWr.subSel && !clkWr.oscSel) |=> mainSelected)
		else $error("main not selected with both other selects clear");

	chk_bad_route_low: assert property (@(posedge clk_sys) disable iff (!nrst)
		clkEn && !mainSelected && !(subSel_q && !directSel_q && src_q == SRC_SUB) |=> !clockOutputPin)
		else $error("clock output driven without a legal route");

	chk_direct_follows: assert property (@(posedge clk_sys) disable iff (!nrst)
		clkEn && mainSelected && directSel_q && src_q == SRC_MAIN |=> clockOutputPin == $past(mainClkIn))
		else $error("direct main output wrong");

	chk_div8_out: assert property (@(posedge clk_sys) disable iff (!nrst)
		clkEn && mainSelected && !directSel_q && src_q == SRC_DIV8 |=> clockOutputPin == $past(div8))
		else $error("div8 output wrong");

	chk_div32_out: assert property (@(posedge clk_sys) disable iff (!nrst)
		clkEn && mainSelected && !directSel_q && src_q == SRC_DIV32 |=> clockOutputPin == $past(div32))
		else $error("div32 output wrong");

	// checker helper: main edges counted since the last visible div8 toggle, kept apart from the cell's counter
	logic div8Prev_q;
	logic [4:0] div8Gap_q;
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			div8Prev_q <= 1'b0;
			div8Gap_q <= 5'h0;
		end
		else if (clkEn)
		begin
			div8Prev_q <= div8;
			if (div8 != div8Prev_q)
				div8Gap_q <= {4'h0, mainEdge};
			else if (mainEdge)
				div8Gap_q <= div8Gap_q + 5'h1;
		end
	end

	chk_div8_gap: assert property (@(posedge clk_sys) disable iff (!nrst)
		clkEn && div8 != div8Prev_q |-> div8Gap_q == 5'(DIV8_HALF))
		else $error("div8 half period wrong");

	chk_div32_step: assert property (@(posedge clk_sys) disable iff (!nrst)
		clkEn && !mainEdge |=> $stable(div32))
		else $error("div32 moved without a main edge");

	chk_sub_out: assert property (@(posedge clk_sys) disable iff (!nrst)
		clkEn && subSel_q && !directSel_q && src_q == SRC_SUB |=> clockOutputPin == $past(subClkIn))
		else $error("sub clock output wrong");

	chk_flash_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
		rdReq.req && rdReq.isDataFlash && (waitInsertBit || dataFlashWaitBit) |-> readWait)
		else $error("data flash wait missing");

	chk_strap_blocks: assert property (@(posedge clk_sys) disable iff (!nrst)
		strapCaught_q && rdReq.req |-> !progRomGrant)
		else $error("program memory read granted under strap");

	chk_strap_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
		clkEn && !armed_q && processorModeStrap |=> progRomBlock)
		else $error("strap high at reset release did not block program memory");

	chk_strap_held: assert property (@(posedge clk_sys) disable iff (!nrst)
		progRomBlock |=> progRomBlock)
		else $error("program memory block dropped before reset");
endmodule

// *** verif/cop_osc_model.sv ***
`timescale 1ns/10ps
// Purpose: external main and sub clock sources
// Assumes: levels move on the falling edge of clk_sys
// Notes: main toggles every 4 cycles, sub every 12
module cop_osc_model
(
	// system clock
	input wire logic clk_sys,
	// oscillator levels
	output logic mainClkIn,
	output logic subClkIn
);
	int n = 0;
	logic mainLvl = 1'b0;
	logic subLvl = 1'b0;
	assign mainClkIn = mainLvl;
	assign subClkIn = subLvl;
	// free running; a stopped main clock would hang the cpu
	// main at an eighth of clk_sys keeps even the direct output below the bus clock
	always @(negedge clk_sys)
	begin
		n <= n + 1;
		if (n % 4 == 3)
			mainLvl <= ~mainLvl;
		// sub runs from time zero, so it is long settled before the bench switches to it
		if (n % 12 == 11)
			subLvl <= ~subLvl;
	end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/10ps
// Purpose: self-checking bench for the clock control block
// Assumes: inputs driven on the falling edge
// Notes: divided outputs judged by edge counts, as their phase is a design choice
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
	import cop_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic unlock = 1'b0;
	logic wib = 1'b0;
	logic dfw = 1'b0;
	logic strap = 1'b0;
	logic useSub = 1'b0;
	logic clkEn = 1'b1;
	logic pinHeld;
	logic mainClkIn, subClkIn, pin, mainSel, readWait, romBlock, romGrant;
	logic [1:0] hist = 2'h0;
	logic pinPrev = 1'b0;
	cop_clkwr_t clkWr = '0;
	cop_rdreq_t rdReq = '0;
	int err_count = 0;
	int n_tests = 0;
	int seed = 32'h3d3aadc1;
	int rnd, mode = 0, rises = 0, mSub = 0, mOsc = 0;
	cop_osc_model osc (.clk_sys(clk_sys), .mainClkIn(mainClkIn), .subClkIn(subClkIn));
	cop_clock_ctl uut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .mainClkIn(mainClkIn),
		.subClkIn(subClkIn), .clockWriteUnlock(unlock), .clkWr(clkWr), .waitInsertBit(wib),
		.dataFlashWaitBit(dfw), .processorModeStrap(strap), .rdReq(rdReq), .clockOutputPin(pin),
		.mainSelected(mainSel), .readWait(readWait), .progRomBlock(romBlock), .progRomGrant(romGrant));
	always #20 clk_sys = ~clk_sys;
	// source history and output rise count
	always @(posedge clk_sys)
	begin
		hist <= {hist[0], useSub ? subClkIn : mainClkIn};
		pinPrev <= pin;
		if (pin && !pinPrev)
			rises++;
	end
	// output may lag one or two edges, so judge only where the source held, except in mode 3 where the pin must stay low
	always @(negedge clk_sys)
		if (nrst && mode != 0 && (mode == 3 || hist[0] == hist[1]))
			`CHK("clockOutputPin", (mode == 3) ? 1'b0 : hist[0], pin)
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wr(input logic u, s, o, d, input logic [1:0] f);
		clkWr <= '{1'b1, s, o, d, f};
		unlock <= u;
		cyc(1);
		clkWr.wrEn <= 1'b0;
		unlock <= 1'b0;
		if (u)
		begin
			mSub = s;
			mOsc = o;
		end
		cyc(1);
		`CHK("mainSelected", (mSub == 0 && mOsc == 0), mainSel)
	endtask
	task automatic stop_test;
		$display("Tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#(40 * 6000);
		err_count++;
		stop_test;
	end
	// software side by
	// never setting the stop detect, wait, stop, flash mode, ready or timer bits; none reach this block
	// main sequence
	initial
	begin
		cyc(10);
		nrst <= 1'b1;
		cyc(2);
		`CHK("progRomBlock", 1'b0, romBlock)
		wr(1, 0, 0, 1, SRC_MAIN);
		mode = 1;
		cyc(40);
		wr(0, 1, 0, 0, SRC_SUB);
		`CHK("mainSelected", 1'b1, mainSel)
		cyc(40);
		mode = 0;
		wr(1, 0, 0, 0, SRC_DIV8);
		rises = 0;
		cyc(256);
		`CHK("div8Edges", 1'b1, rises >= 3 && rises <= 5)
		wr(1, 0, 0, 0, SRC_DIV32);
		rises = 0;
		cyc(1024);
		`CHK("div32Edges", 1'b1, rises >= 3 && rises <= 5)
		useSub = 1'b1;
		wr(1, 1, 0, 0, SRC_SUB);
		cyc(1);
		mode = 1;
		cyc(60);
		mode = 0;
		// a low clock enable must hold the output while the sub clock keeps moving
		clkEn <= 1'b0;
		cyc(1);
		pinHeld = pin;
		repeat (30)
		begin
			cyc(1);
			`CHK("frozenPin", pinHeld, pin)
		end
		clkEn <= 1'b1;
		wr(1, 0, 1, 1, SRC_MAIN);
		cyc(1);
		mode = 3;
		cyc(20);
		mode = 0;
		// random read traffic
		repeat (20)
		begin
			rnd = $random(seed);
			{rdReq, wib, dfw} = rnd[4:0];
			#1;
			`CHK("readWait", rdReq.req & rdReq.isDataFlash & (wib | dfw), readWait)
			`CHK("progRomGrant", rdReq.req & rdReq.isProgRom & !strap, romGrant)
			cyc(1);
		end
		strap <= 1'b1;
		nrst <= 1'b0;
		cyc(10);
		nrst <= 1'b1;
		rdReq <= '{1'b1, 1'b0, 1'b1};
		cyc(3);
		`CHK("progRomBlock", 1'b1, romBlock)
		`CHK("progRomGrant", 1'b0, romGrant)
		mSub = 0;
		mOsc = 0;
		`CHK("mainSelected", 1'b1, mainSel)
		stop_test;
	end
endmodule
